// ### src/sslc_port.v
// Serial load port of the synthesizer: shift register, word latches and the
// counter hold control. Assumes the four pins are asynchronous to clk.
//
// Notes on behaviour
// - While the hold bit is set, counters sit at load point and pump is off.
// - The hold bit never requests a synchronous power-down.
// - Reloading function with hold cleared releases the counters while chip enable is high.
// - Release restarts counters from load point, as initialization does.
// - Data is sampled into a 24-bit shift register on each rising clock.
// - A rising strobe copies the word to the latch named by its two LSBs.
// - The port is write only and offers no read-back.
// - Code 11 loads the function latch too and pulses a counter reset.
// - Shifting and latching keep working during any power-down.
`include "sslc_regs.vh"
`timescale 1ns/1ps
module sslc_port #(
  parameter PULSE_CYC = `SSLC_PULSE_CYC
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Serial pins
  input  wire        serial_clk,
  input  wire        serial_data,
  input  wire        word_transfer_strobe,
  input  wire        chip_enable,
  // Latch contents
  output reg  [23:0] reference_divider_latch,
  output reg  [23:0] feedback_divider_latch,
  output reg  [23:0] function_config_latch,
  // Counter and pump control
  output reg         counter_hold_bit,
  output reg         counters_at_load,
  output reg         pump_three_state,
  output reg         sync_pd_req,
  output reg         async_pd
);
  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  wire sclk_s;
  wire sdat_s;
  wire stb_s;
  wire ce_s;
  sslc_sync #(
    .RST_VAL (1'b0)
  ) u_sclk (
    .clk  (clk),
    .rst  (rst),
    .din  (serial_clk),
    .dout (sclk_s)
  );
  sslc_sync #(
    .RST_VAL (1'b0)
  ) u_sdat (
    .clk  (clk),
    .rst  (rst),
    .din  (serial_data),
    .dout (sdat_s)
  );
  // The strobe idles high, so its flops reset high to avoid a false edge.
  sslc_sync #(
    .RST_VAL (1'b1)
  ) u_stb (
    .clk  (clk),
    .rst  (rst),
    .din  (word_transfer_strobe),
    .dout (stb_s)
  );
  sslc_sync #(
    .RST_VAL (1'b0)
  ) u_ce (
    .clk  (clk),
    .rst  (rst),
    .din  (chip_enable),
    .dout (ce_s)
  );

  // ------------------------------------------------------------
  // Shift register
  // ------------------------------------------------------------
  // Data is delayed the same two flops as the clock, so set-up is preserved;
  // the serial clock must stay high and low for at least two clk periods.
  reg        sclk_d_r;
  reg        stb_d_r;
  reg [23:0] shift_r;
  wire       sclk_rise = sclk_s & ~sclk_d_r;
  wire       stb_rise  = stb_s & ~stb_d_r;

  // Tests the two control bits of a word against one latch code.
  function code_is;
    input [23:0] word;
    input [1:0]  sel;
    begin
      code_is = (word[`SSLC_CODE_MSB:`SSLC_CODE_LSB] == sel);
    end
  endfunction

  // The strobe edge detector resets high, matching the idle strobe level.
  always @(posedge clk) begin
    if (rst) begin
      sclk_d_r <= 1'b0;
      stb_d_r  <= 1'b1;
      shift_r  <= `SSLC_LATCH_RESET;
    end else begin
      sclk_d_r <= sclk_s;
      stb_d_r  <= stb_s;
      // Shifting ignores chip enable and the power-down bits.
      if (sclk_rise) begin
        shift_r <= {shift_r[22:0], sdat_s};
      end
    end
  end

  // ------------------------------------------------------------
  // Word decode
  // ------------------------------------------------------------
  wire load_ref  = stb_rise & code_is(shift_r, `SSLC_CODE_REF);
  wire load_fb   = stb_rise & code_is(shift_r, `SSLC_CODE_FB);
  wire load_func = stb_rise & code_is(shift_r, `SSLC_CODE_FUNC);
  wire load_init = stb_rise & code_is(shift_r, `SSLC_CODE_INIT);

  // ------------------------------------------------------------
  // Word latches
  // ------------------------------------------------------------
  // No read path exists; latches only ever leave as control outputs.
  reg [23:0] ref_nxt;
  reg [23:0] fb_nxt;
  reg [23:0] func_nxt;

  always @* begin
    ref_nxt  = reference_divider_latch;
    fb_nxt   = feedback_divider_latch;
    func_nxt = function_config_latch;
    if (load_ref) begin
      ref_nxt = shift_r;
    end else if (load_fb) begin
      fb_nxt = shift_r;
    end else if (load_func) begin
      func_nxt = shift_r;
    end else if (load_init) begin
      func_nxt = shift_r;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      reference_divider_latch <= `SSLC_LATCH_RESET;
      feedback_divider_latch  <= `SSLC_LATCH_RESET;
      function_config_latch   <= `SSLC_LATCH_RESET;
    end else begin
      reference_divider_latch <= ref_nxt;
      feedback_divider_latch  <= fb_nxt;
      function_config_latch   <= func_nxt;
    end
  end

  // ------------------------------------------------------------
  // Internal counter reset pulse
  // ------------------------------------------------------------
  // An initialization word fires the pulse and arms a second one for the
  // first feedback load after it; later feedback loads leave counters alone.
  // PULSE_CYC must lie between 1 and 7 to fit the three-bit counter.
  localparam [3:0] ST_RUN   = 4'h1;
  localparam [3:0] ST_INITP = 4'h2;
  localparam [3:0] ST_ARMED = 4'h4;
  localparam [3:0] ST_FBP   = 4'h8;

  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [2:0] pulse_cnt_r;
  reg [2:0] pulse_cnt_nxt;
  wire      pulse_on = (state_r == ST_INITP) | (state_r == ST_FBP);
  wire      fb_armed = (state_r == ST_INITP) | (state_r == ST_ARMED);

  always @* begin
    state_nxt     = state_r;
    pulse_cnt_nxt = pulse_cnt_r;
    case (state_r)
      ST_INITP: begin
        pulse_cnt_nxt = pulse_cnt_r - 3'h1;
        if (pulse_cnt_r == 3'h1) begin
          state_nxt = ST_ARMED;
        end
      end
      ST_FBP: begin
        pulse_cnt_nxt = pulse_cnt_r - 3'h1;
        if (pulse_cnt_r == 3'h1) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt     = state_r;
        pulse_cnt_nxt = pulse_cnt_r;
      end
    endcase
    if (load_init) begin
      state_nxt     = ST_INITP;
      pulse_cnt_nxt = PULSE_CYC[2:0];
    end else if (load_fb && fb_armed) begin
      state_nxt     = ST_FBP;
      pulse_cnt_nxt = PULSE_CYC[2:0];
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      state_r     <= ST_RUN;
      pulse_cnt_r <= 3'h0;
    end else begin
      state_r     <= state_nxt;
      pulse_cnt_r <= pulse_cnt_nxt;
    end
  end

  // ------------------------------------------------------------
  // Counter hold and pump control
  // ------------------------------------------------------------
  // Counters are held at load point rather than stopped mid-count, so a
  // release always restarts from the same phase.
  wire hold_now    = function_config_latch[`SSLC_HOLD_BIT];
  wire pd1         = function_config_latch[`SSLC_PD1_BIT];
  wire pd2         = function_config_latch[`SSLC_PD2_BIT];
  wire at_load_nxt = hold_now | pulse_on | ~ce_s;
  wire pump_nxt    = at_load_nxt | function_config_latch[`SSLC_CP3S_BIT];

  always @(posedge clk) begin
    if (rst) begin
      counter_hold_bit <= 1'b0;
      counters_at_load <= 1'b0;
      pump_three_state <= 1'b0;
      sync_pd_req      <= 1'b0;
      async_pd         <= 1'b0;
    end else begin
      counter_hold_bit <= hold_now;
      counters_at_load <= at_load_nxt;
      pump_three_state <= pump_nxt;
      // Only the power-down bits and chip enable reach these, never hold.
      sync_pd_req      <= ce_s & pd1 & pd2;
      async_pd         <= ~ce_s | (pd1 & ~pd2);
    end
  end
endmodule

// ### src/sslc_regs.vh
// Latch codes, field positions and timing constants for the serial load port.
// Included by the port only; holds definitions only.
`ifndef SSLC_REGS_VH
`define SSLC_REGS_VH
`define SSLC_CODE_REF       2'h0
`define SSLC_CODE_FB        2'h1
`define SSLC_CODE_FUNC      2'h2
`define SSLC_CODE_INIT      2'h3
`define SSLC_WORD_BITS      24
`define SSLC_CODE_LSB       0
`define SSLC_CODE_MSB       1
`define SSLC_HOLD_BIT       2
`define SSLC_PD1_BIT        3
`define SSLC_PD2_BIT        21
`define SSLC_CP3S_BIT       4
`define SSLC_LATCH_RESET    24'h000000
`define SSLC_CLK_MHZ        100
`define SSLC_SCLK_MAX_MHZ   20
`define SSLC_PULSE_CYC      4
`endif

// ### src/sslc_sync.v
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes the input is asynchronous to clk; only stage two is read.
`timescale 1ns/1ps
// The reset level is a parameter so an idle-high pin shows no false edge.
module sslc_sync #(
  parameter RST_VAL = 1'b0
) (
  // Clock and reset
  input  wire clk,
  input  wire rst,
  // Level
  input  wire din,
  output wire dout
);
  reg meta_r;
  reg sync_r;
  always @(posedge clk) begin
    if (rst) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
    end
  end
  assign dout = sync_r;
endmodule

// ### testbench/sslc_port_checker.sv
// Concurrent checks on the serial load port pins, bound to sslc_port.
// Assumes control outputs follow latch updates by one clock.
`timescale 1ns/1ps
module sslc_port_checker (
  // Clock and reset
  input wire        clk,
  input wire        rst,
  // Serial pins
  input wire        serial_clk,
  input wire        serial_data,
  input wire        chip_enable,
  input wire        word_transfer_strobe,
  // Latch contents
  input wire [23:0] reference_divider_latch,
  input wire [23:0] feedback_divider_latch,
  input wire [23:0] function_config_latch,
  // Counter and pump control
  input wire        counter_hold_bit,
  input wire        counters_at_load,
  input wire        pump_three_state,
  input wire        sync_pd_req,
  input wire        async_pd
);
  wire [23:0] rl = reference_divider_latch;
  wire [23:0] fl = feedback_divider_latch;
  wire [23:0] cl = function_config_latch;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  hold_blocks_a: assert property (counter_hold_bit |->
    counters_at_load && pump_three_state) else $error("hold leak");
  hold_follow_a: assert property (counter_hold_bit == $past(cl[2]))
    else $error("hold bit stale");
  no_sync_pd_a: assert property (counter_hold_bit && !$past(cl[3]) |->
    !sync_pd_req) else $error("hold raised power-down");
  ref_code_a: assert property ($changed(rl) |-> rl[1:0] == 2'h0)
    else $error("bad reference code");
  fb_code_a: assert property ($changed(fl) |-> fl[1:0] == 2'h1)
    else $error("bad feedback code");
  func_code_a: assert property ($changed(cl) |-> cl[1])
    else $error("bad function code");
  init_pulse_a: assert property ($changed(cl) && cl[1:0] == 2'h3 |=>
    counters_at_load [*4]) else $error("init pulse short");
  release_a: assert property ($fell(counter_hold_bit) && chip_enable |->
    !counters_at_load) else $error("counters not released");
  cover property (counter_hold_bit);
  cover property ($fell(counter_hold_bit));
  cover property (async_pd && $changed(rl));
endmodule
bind sslc_port sslc_port_checker chk (.*);

// ### testbench/sslc_host.sv
// Host model of the serial pins: MSB first, 80 ns serial clock.
// Assumes clk runs at 100 MHz; data is inverted once released.
`timescale 1ns/1ps
module sslc_host (
  // Clock
  input wire clk,
  // Serial pins
  output reg sclk,
  output reg sdata,
  output reg strobe
);
  integer i;
  initial begin
    sclk = 1'b0;
    sdata = 1'b0;
    strobe = 1'b1;
  end
  task send(input [23:0] w);
    begin
      @(negedge clk) strobe = 1'b0;
      for (i = 23; i >= 0; i = i - 1) begin
        sdata = w[i];
        repeat (4) @(negedge clk);
        sclk = 1'b1;
        repeat (4) @(negedge clk);
        sclk = 1'b0;
      end
      sdata = ~sdata;
      strobe = 1'b1;
    end
  endtask
endmodule

// ### testbench/sslc_port_test.sv
// Bench for the serial load port; the host model shifts every word.
// Expected values come from the words sent.
`timescale 1ns/1ps
module sslc_port_test;
  reg         clk, rst, ce;
  wire        sclk, sdata, strobe, hold, at_load, pump, spd, apd;
  wire [23:0] rl, fl, cl;
  wire [23:0] ctl = {19'h0, hold, at_load, pump, spd, apd};
  integer     error_cnt = 0;
  integer     tests_run = 0;
  sslc_host host (.clk(clk), .sclk(sclk), .sdata(sdata), .strobe(strobe));
  sslc_port dut (.clk(clk), .rst(rst), .serial_clk(sclk),
    .serial_data(sdata), .word_transfer_strobe(strobe), .chip_enable(ce),
    .reference_divider_latch(rl), .feedback_divider_latch(fl),
    .function_config_latch(cl), .counter_hold_bit(hold),
    .counters_at_load(at_load), .pump_three_state(pump),
    .sync_pd_req(spd), .async_pd(apd));
  task chk(input [23:0] got, input [23:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task load(input [23:0] w);
    begin
      host.send(w);
      repeat (6) @(negedge clk);
    end
  endtask
  task final_report;
    begin
      $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task t_counter_reset;
    begin
      load(24'h000006);
      chk(ctl, 24'h00001C);
      load(24'hA5C3C0);
      chk(rl, 24'hA5C3C0);
      load(24'h3C5A61);
      chk(fl, 24'h3C5A61);
      chk(ctl, 24'h00001C);
      load(24'h000002);
      chk(ctl, 24'h000000);
      $display("counter reset test done");
    end
  endtask
  task t_init_pd;
    begin
      load(24'h800003);
      chk(cl, 24'h800003);
      chk(rl, 24'hA5C3C0);
      ce = 1'b0;
      load(24'h0F0F0C);
      chk(rl, 24'h0F0F0C);
      chk(ctl, 24'h00000D);
      ce = 1'b1;
      $display("init and power-down test done");
    end
  endtask
  task t_power_up;
    begin
      load(24'h000003);
      chk(ctl, 24'h00000C);
      load(24'h000012);
      chk(ctl, 24'h000004);
      load(24'h123400);
      chk(rl, 24'h123400);
      load(24'h00ABC1);
      chk(ctl, 24'h00000C);
      repeat (2) @(negedge clk);
      chk(ctl, 24'h000004);
      load(24'h00ABC5);
      chk(fl, 24'h00ABC5);
      chk(ctl, 24'h000004);
      load(24'h20000A);
      chk(ctl, 24'h000002);
      load(24'h00000A);
      chk(ctl, 24'h000001);
      load(24'h000002);
      chk(ctl, 24'h000000);
      $display("power-up and pulse test done");
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    chk(cl, 24'h000000);
    t_counter_reset;
    t_init_pd;
    t_power_up;
    final_report;
  end
  initial begin
    #100000;
    error_cnt = error_cnt + 1;
    final_report;
  end
endmodule
